// [design/spm_port.sv]
`timescale 1ns/100ps
// Notes on behaviour
// R1: output driven, changes on falling clock
// R2: sample input on rising edges after select
// R3: deselected means output released, standby
// R4: nothing accepted before first select fall
// R5: guard low with enable blocks status program
// R6: guard fall while selected aborts status program
// R7: enable clear makes guard pin ignored
// R8: pause freezes sequence while selected
// R9: host moves pause only with clock low
// R10: resume at same bit after pause
// R11: eight bit instruction register per sequence
// R12: host keeps select, pause, guard steady
// R13: all bytes travel msb first
// R14: stopped serial clock is harmless
// R15: no program completes without latch
// R16: set and clear latch instructions
// R17: latch clears at reset and cycle end
// R18: status readable any time, even busy
// R19: status layout enable, locks, latch, busy
// R20: latch and busy flags read only
// R21: busy reads one, others one meanwhile
// R22: lock select protects quarters of array
// R23: set latch 06, clear latch 04
// R24: status read 05, status program 01
// R25: host writes zeros in unused bits
// R26: busy and latch clear together
module spm_port #(
  parameter int PROG_CYCLES = spm_pkg::PROG_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic       write_guard_n,
  input  wire logic       array_busy,
  input  wire logic       array_prog_done,
  input  wire logic [1:0] addr_quarter,
  output logic            so,
  output logic            so_oe,
  output logic            prog_enable,
  output logic            prog_busy,
  output logic            guard_pin_enable,
  output logic [1:0]      lock_sel,
  output logic            addr_locked
);

  spm_pkg::spm_state_t s;
  spm_pkg::spm_state_t next_s;
  spm_pkg::spm_pins_t  pins_raw;
  spm_pkg::spm_pins_t  pins;
  logic [spm_pkg::SYN_W-1:0] pins_q;

  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       active;
  logic       paused;
  logic       rise_ok;
  logic       fall_ok;
  logic       busy_any;
  logic       guard_block;
  logic [7:0] status_word;
  logic [7:0] byte_in;

  // pin vector by name; the synchroniser input below takes these pins in reverse bit order
  always_comb begin
    pins_raw         = '0;
    pins_raw.cs_n    = cs_n;
    pins_raw.sck     = sck;
    pins_raw.si      = si;
    pins_raw.hold_n  = hold_n;
    pins_raw.guard_n = write_guard_n;
  end

  spm_sync #(
    .W       (spm_pkg::SYN_W),
    .RST_VAL (spm_pkg::SYNC_RST)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({pins_raw.guard_n, pins_raw.hold_n, pins_raw.si,
           pins_raw.sck, pins_raw.cs_n}),
    .q   (pins_q)
  );

  // unpack synchronised pins
  always_comb begin
    pins         = '0;
    pins.cs_n    = pins_q[spm_pkg::SYN_CS];
    pins.sck     = pins_q[spm_pkg::SYN_SCK];
    pins.si      = pins_q[spm_pkg::SYN_SI];
    pins.hold_n  = pins_q[spm_pkg::SYN_HOLD];
    pins.guard_n = pins_q[spm_pkg::SYN_GUARD];
  end

  // edge finding on the sampled serial clock and select
  assign sck_rise = pins.sck & ~s.sck_q;
  assign sck_fall = ~pins.sck & s.sck_q;
  // R4: select fall needs a seen high first
  assign cs_fall  = ~pins.cs_n & s.cs_q;
  assign cs_rise  = pins.cs_n & ~s.cs_q;
  assign active   = ~pins.cs_n & ~s.cs_q & (s.mode != spm_pkg::mode_idle);
  // R8: pause gates every serial edge
  assign paused   = active & ~pins.hold_n;
  // R14: edges only, so the serial clock may slow down or stop
  assign rise_ok  = active & pins.hold_n & sck_rise;
  assign fall_ok  = active & pins.hold_n & sck_fall;
  assign busy_any = s.busy_sr | array_busy;
  // R13: msb arrives first, shifted in from the right
  assign byte_in  = {s.shreg[6:0], pins.si};

  // R5: guard low with enable set refuses status program
  // R6: any guard fall during the frame also refuses
  // R7: enable clear leaves the guard pin without effect
  assign guard_block = s.pen & (~pins.guard_n | s.guard_fell);

  // status image as read back
  always_comb begin
    status_word = '0;
    // R19: field placement in the status byte
    status_word[spm_pkg::ST_PEN]   = s.pen;
    status_word[spm_pkg::ST_BL_HI] = s.bl[1];
    status_word[spm_pkg::ST_BL_LO] = s.bl[0];
    // R20: read-only flags from the latch state and busy_any, which also takes the array_busy input
    status_word[spm_pkg::ST_LATCH] = s.latch;
    status_word[spm_pkg::ST_BUSY]  = busy_any;
    // R21: all ones while programming
    if (busy_any) begin
      status_word = spm_pkg::ST_ALL_ONES;
    end
  end

  // whole next state of the port
  always_comb begin
    next_s         = s;
    next_s.cs_q    = pins.cs_n;
    next_s.sck_q   = pins.sck;
    next_s.guard_q = pins.guard_n;

    // frame start resets the bit position
    if (cs_fall) begin
      next_s.mode       = spm_pkg::mode_opcode;
      next_s.bit_cnt    = '0;
      next_s.out_cnt    = '0;
      next_s.guard_fell = 1'b0;
    end

    // guard falls seen while selected
    if (~pins.cs_n & ~pins.guard_n & s.guard_q) begin
      next_s.guard_fell = 1'b1;
    end

    // R2: input bits taken on rising serial clock
    if (rise_ok) begin
      next_s.shreg = byte_in;
      if (s.bit_cnt != spm_pkg::BIT_MAX) begin
        next_s.bit_cnt = s.bit_cnt + 5'h01;
      end
      // R11: eighth bit completes the instruction
      if ((s.mode == spm_pkg::mode_opcode) &&
          (s.bit_cnt == spm_pkg::BIT_OPCODE_LAST)) begin
        next_s.opcode = byte_in;
        // R18: status read accepted even when busy
        if (byte_in == spm_pkg::OP_STATUS_READ) begin
          next_s.mode = spm_pkg::mode_read;
        end else begin
          next_s.mode = spm_pkg::mode_skip;
        end
      end
    end

    // R1: output bit changes on the falling clock
    if (fall_ok && (s.mode == spm_pkg::mode_read)) begin
      if (s.out_cnt == 3'h0) begin
        next_s.so     = status_word[7];
        next_s.out_sh = {status_word[6:0], 1'b0};
      end else begin
        next_s.so     = s.out_sh[7];
        next_s.out_sh = {s.out_sh[6:0], 1'b0};
      end
      next_s.out_cnt = s.out_cnt + 3'h1;
    end

    // select rise ends the frame and acts on it
    if (cs_rise) begin
      next_s.mode = spm_pkg::mode_idle;
      // R16: latch set or cleared on exact length frame
      // R23: latch instruction codes
      if (!busy_any && (s.bit_cnt == spm_pkg::BIT_OPCODE_END)) begin
        if (s.opcode == spm_pkg::OP_SET_LATCH) begin
          next_s.latch = 1'b1;
        end else if (s.opcode == spm_pkg::OP_CLEAR_LATCH) begin
          next_s.latch = 1'b0;
        end
      end
      // R24: status program needs one data byte
      // R15: latch must be set to start the cycle
      if (!busy_any && (s.bit_cnt == spm_pkg::BIT_PROG_END) &&
          (s.opcode == spm_pkg::OP_STATUS_PROG) && s.latch &&
          !guard_block) begin
        next_s.busy_sr = 1'b1;
        next_s.pend    = s.shreg;
        next_s.timer   = spm_pkg::spm_tmr_t'(PROG_CYCLES - 1);
      end
    end

    // self-timed status program cycle
    if (s.busy_sr) begin
      if (s.timer == '0) begin
        next_s.pen = s.pend[spm_pkg::ST_PEN];
        next_s.bl  = s.pend[spm_pkg::ST_BL_HI:spm_pkg::ST_BL_LO];
        // R26: busy and latch drop in one step
        // R17: latch cleared at end of write cycle
        next_s.busy_sr = 1'b0;
        next_s.latch   = 1'b0;
      end else begin
        next_s.timer = s.timer - spm_pkg::spm_tmr_t'(1);
      end
    end

    // R17: sector program completion clears latch
    if (array_prog_done) begin
      next_s.latch = 1'b0;
    end

    // R3: released whenever deselected
    next_s.so_oe = ~pins.cs_n & (next_s.mode == spm_pkg::mode_read);

    // R22: quarter protection from lock select
    unique case (s.bl)
      spm_pkg::LOCK_NONE: next_s.addr_locked = 1'b0;
      spm_pkg::LOCK_QTR:  next_s.addr_locked =
                            (addr_quarter == spm_pkg::QTR_TOP);
      spm_pkg::LOCK_HALF: next_s.addr_locked = addr_quarter[1];
      spm_pkg::LOCK_ALL:  next_s.addr_locked = 1'b1;
    endcase
  end

  // R10: paused state is simply held
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= spm_pkg::SPM_ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign so               = s.so;
  assign so_oe            = s.so_oe;
  assign prog_enable      = s.latch;
  assign prog_busy        = s.busy_sr;
  assign guard_pin_enable = s.pen;
  assign lock_sel         = s.bl;
  assign addr_locked      = s.addr_locked;

  // checks on the running design
  a_desel_release: assert property (@(posedge clk) disable iff (rst) // R3
    pins.cs_n |=> !so_oe)
    else $error("output enabled while deselected");

  a_so_falling: assert property (@(posedge clk) disable iff (rst) // R1
    (s.so_oe && !fall_ok) |=> (s.so == $past(s.so)))
    else $error("serial output moved off a falling edge");

  a_bit_advance: assert property (@(posedge clk) disable iff (rst) // R2
    (rise_ok && !cs_fall && (s.bit_cnt < spm_pkg::BIT_PROG_END))
      |=> (s.bit_cnt == $past(s.bit_cnt) + 5'h01))
    else $error("rising edge not counted");

  a_pause_hold: assert property (@(posedge clk) disable iff (rst) // R8
    paused |=> ($stable(s.bit_cnt) && $stable(s.shreg) && $stable(s.so)))
    else $error("sequence moved during pause");

  a_start_latch: assert property (@(posedge clk) disable iff (rst) // R15
    $rose(s.busy_sr) |-> $past(s.latch))
    else $error("program cycle started without latch");

  a_start_guard: assert property (@(posedge clk) disable iff (rst) // R5
    $rose(s.busy_sr) |-> !($past(s.pen) && !$past(pins.guard_n)))
    else $error("status program under guard");

  a_guard_abort: assert property (@(posedge clk) disable iff (rst) // R6
    $rose(s.busy_sr) |-> !($past(s.pen) && $past(s.guard_fell)))
    else $error("guard fall did not abort");

  a_latch_source: assert property (@(posedge clk) disable iff (rst) // R16
    $rose(s.latch) |-> ($past(s.opcode) == spm_pkg::OP_SET_LATCH) &&
                       ($past(s.mode) != spm_pkg::mode_idle))
    else $error("latch set without set instruction");

  a_done_clears: assert property (@(posedge clk) disable iff (rst) // R17
    array_prog_done |=> !s.latch)
    else $error("latch survived program completion");

  a_end_together: assert property (@(posedge clk) disable iff (rst) // R26
    $fell(s.busy_sr) |-> !s.latch)
    else $error("latch still set at cycle end");

  a_lock_all: assert property (@(posedge clk) disable iff (rst) // R22
    (s.bl == spm_pkg::LOCK_ALL) |=> s.addr_locked)
    else $error("whole array not locked");

  c_status_prog: cover property (@(posedge clk) disable iff (rst)
    $rose(s.busy_sr));
  c_status_read: cover property (@(posedge clk) disable iff (rst)
    $rose(s.so_oe));
  c_pause: cover property (@(posedge clk) disable iff (rst)
    paused ##1 !paused);
  c_guard_abort: cover property (@(posedge clk) disable iff (rst)
    cs_rise && s.guard_fell && s.pen);

endmodule

// [design/spm_sync.sv]
`timescale 1ns/100ps
module spm_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spm_sync_st_t;

  spm_sync_st_t r;
  spm_sync_st_t next_r;

  // two stages; only the second stage is read outside
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule

// [include/spm_pkg.sv]
package spm_pkg;

  // pin sample vector, one bit per synchronised pin
  localparam int SYN_CS    = 0;
  localparam int SYN_SCK   = 1;
  localparam int SYN_SI    = 2;
  localparam int SYN_HOLD  = 3;
  localparam int SYN_GUARD = 4;
  localparam int SYN_W     = 5;
  // cs and sck low, si low, pause and guard high
  localparam logic [SYN_W-1:0] SYNC_RST = 5'h18;

  // instruction codes, msb first on the wire
  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_PROG = 8'h01;

  // status field positions
  localparam int ST_PEN     = 7;
  localparam int ST_BL_HI   = 3;
  localparam int ST_BL_LO   = 2;
  localparam int ST_LATCH   = 1;
  localparam int ST_BUSY    = 0;
  localparam logic [7:0] ST_ALL_ONES = 8'hff;

  // lock select encodings
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_QTR  = 2'h1;
  localparam logic [1:0] LOCK_HALF = 2'h2;
  localparam logic [1:0] LOCK_ALL  = 2'h3;
  localparam logic [1:0] QTR_TOP   = 2'h3;

  // nonvolatile bits after power-up
  localparam logic       PEN_RST = 1'b0;
  localparam logic [1:0] BL_RST  = 2'h0;

  // bit counting within one selected sequence
  localparam logic [4:0] BIT_OPCODE_LAST = 5'h07;
  localparam logic [4:0] BIT_OPCODE_END  = 5'h08;
  localparam logic [4:0] BIT_PROG_END    = 5'h10;
  localparam logic [4:0] BIT_MAX         = 5'h1f;

  // self-timed program cycle
  localparam int PROG_TIME_US = 5000;
  localparam int CLK_MHZ      = 20;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int TIMER_W      = 24;
  typedef logic [TIMER_W-1:0] spm_tmr_t;

  typedef enum logic [1:0] {
    mode_idle,
    mode_opcode,
    mode_read,
    mode_skip
  } spm_mode_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic guard_n;
  } spm_pins_t;

  typedef struct packed {
    spm_mode_t  mode;
    logic       cs_q;
    logic       sck_q;
    logic       guard_q;
    logic [4:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] opcode;
    logic [7:0] pend;
    logic [2:0] out_cnt;
    logic [7:0] out_sh;
    logic       so;
    logic       so_oe;
    logic       latch;
    logic       pen;
    logic [1:0] bl;
    logic       busy_sr;
    spm_tmr_t   timer;
    logic       guard_fell;
    logic       addr_locked;
  } spm_state_t;

  localparam spm_state_t SPM_ST_RST = '{
    mode    : mode_idle,
    guard_q : 1'b1,
    pen     : PEN_RST,
    bl      : BL_RST,
    default : '0
  };

endpackage

// [test/spm_host_model.sv]
`timescale 1ns/100ps
// host controller on the far side of the serial link
module spm_host_model (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n,
  output logic      write_guard_n
);
  // select starts low, so release of reset shows no fall
  initial begin
    cs_n          = 1'b0;
    sck           = 1'b0;
    si            = 1'b0;
    hold_n        = 1'b1;
    write_guard_n = 1'b1;
  end

  // wait a number of clk cycles
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic select();
    cs_n <= 1'b0;
    idle(8);
  endtask

  task automatic deselect();
    sck  <= 1'b0;
    idle(4);
    cs_n <= 1'b1;
    si   <= ~si;
    idle(12);
  endtask

  task automatic pause();
    hold_n <= 1'b0;
    idle(4);
    repeat (2) begin
      sck <= ~sck;
      si  <= ~si;
      idle(4);
    end
    hold_n <= 1'b1;
    idle(4);
  endtask

  // msb first, set on fall, read before next fall
  task automatic send_byte(input logic [7:0] b, input int pause_at,
                           input int stall_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= b[i];
      idle(4);
      if (i == pause_at) pause();
      sck <= 1'b1;
      idle(3);
      @(negedge clk);
      rx[i] = so_oe ? so : 1'bx;
      idle(1);
      if (i == stall_at) idle(300);
    end
  endtask

  // guard pin level
  task automatic set_guard(input logic v);
    write_guard_n <= v;
    idle(6);
  endtask
endmodule

// [test/test_spm_port.sv]
`timescale 1ns/100ps
// serial port bench: frames from the host model, checks at ports
module test_spm_port;
  logic       clk;
  logic       rst;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       write_guard_n;
  logic       array_busy;
  logic       array_prog_done;
  logic [1:0] addr_quarter;
  logic       so;
  logic       so_oe;
  logic       prog_enable;
  logic       prog_busy;
  logic       guard_pin_enable;
  logic [1:0] lock_sel;
  logic       addr_locked;
  logic [7:0] st;
  int         n_mismatch;
  int         checked;
  logic       rst_pulse;
  logic       arr_go;
  int         rst_left = 4;
  int         arr_left = 0;

  // short program cycle, long enough to read status meanwhile
  spm_port #(.PROG_CYCLES(400)) spm_port_i (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .write_guard_n(write_guard_n),
    .array_busy(array_busy), .array_prog_done(array_prog_done),
    .addr_quarter(addr_quarter), .so(so), .so_oe(so_oe),
    .prog_enable(prog_enable), .prog_busy(prog_busy),
    .guard_pin_enable(guard_pin_enable), .lock_sel(lock_sel),
    .addr_locked(addr_locked)
  );

  spm_host_model spm_host_model_i (
    .clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .write_guard_n(write_guard_n)
  );

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // reset held for 4 edges at start and after each request
  assign rst = (rst_left != 0);
  always @(posedge clk) begin
    if (rst_pulse) begin
      rst_left <= 4;
    end else if (rst_left != 0) begin
      rst_left <= rst_left - 1;
    end
  end

  // array side: busy for a fixed span, then a one-cycle done pulse
  always @(posedge clk) begin
    if (arr_go) begin
      arr_left <= 300;
    end else if (arr_left != 0) begin
      arr_left <= arr_left - 1;
    end
    array_busy      <= (arr_left > 1);
    array_prog_done <= (arr_left == 1);
  end

  // mid-run reset request, returns once reset is released
  task automatic do_reset();
    rst_pulse <= 1'b1;
    @(posedge clk);
    rst_pulse <= 1'b0;
    @(posedge clk);
    while (rst) @(posedge clk);
  endtask

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  // one byte frame
  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    spm_host_model_i.select();
    spm_host_model_i.send_byte(op, -1, -1, rx);
    spm_host_model_i.deselect();
  endtask

  // status program frame, optionally after a latch set
  // callers keep data bits 6 to 4, 1 and 0 at zero
  task automatic prog(input logic [7:0] d, input logic en);
    logic [7:0] rx;
    if (en) cmd(spm_pkg::OP_SET_LATCH);
    spm_host_model_i.select();
    spm_host_model_i.send_byte(spm_pkg::OP_STATUS_PROG, -1, -1, rx);
    spm_host_model_i.send_byte(d, -1, -1, rx);
    spm_host_model_i.deselect();
  endtask

  task automatic rd_status(output logic [7:0] s);
    logic [7:0] rx;
    spm_host_model_i.select();
    spm_host_model_i.send_byte(spm_pkg::OP_STATUS_READ, -1, -1, rx);
    spm_host_model_i.send_byte(8'h00, -1, -1, s);
    spm_host_model_i.deselect();
  endtask

  // bounded wait for the program cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check1(prog_busy, 1'b0);
    check1(prog_enable, 1'b0);
  endtask

  // walk all quarters against the stored lock select
  task automatic check_locks(input logic [1:0] sel);
    logic e;
    for (int q = 0; q < 4; q++) begin
      addr_quarter <= 2'(q);
      repeat (3) @(posedge clk);
      e = (sel == spm_pkg::LOCK_ALL) || (sel == spm_pkg::LOCK_HALF && q >= 2)
          || (sel == spm_pkg::LOCK_QTR && 2'(q) == spm_pkg::QTR_TOP);
      check1(addr_locked, e);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial begin
    logic [7:0] rx;
    rst_pulse       = 1'b0;
    arr_go          = 1'b0;
    addr_quarter    = 2'h0;
    n_mismatch      = 0;
    checked         = 0;
    repeat (4) @(posedge clk);
    spm_host_model_i.idle(4);
    // opcode clocked before any select fall
    spm_host_model_i.send_byte(spm_pkg::OP_SET_LATCH, -1, -1, rx);
    spm_host_model_i.deselect();
    check1(prog_enable, 1'b0);
    rd_status(st);
    check(st, 8'h00);
    check1(so_oe, 1'b0);
    cmd(spm_pkg::OP_SET_LATCH);
    check1(prog_enable, 1'b1);
    rd_status(st);
    check(st, 8'h02);
    cmd(spm_pkg::OP_CLEAR_LATCH);
    check1(prog_enable, 1'b0);
    prog(8'h8c, 1'b0);
    check1(prog_busy, 1'b0);
    // extra byte after the opcode
    spm_host_model_i.select();
    spm_host_model_i.send_byte(spm_pkg::OP_SET_LATCH, -1, -1, rx);
    spm_host_model_i.send_byte(8'h00, -1, -1, rx);
    spm_host_model_i.deselect();
    check1(prog_enable, 1'b0);
    // pause and stopped clock in mid opcode
    spm_host_model_i.select();
    spm_host_model_i.send_byte(spm_pkg::OP_SET_LATCH, 3, 5, rx);
    spm_host_model_i.deselect();
    check1(prog_enable, 1'b1);
    prog(8'h8c, 1'b0);
    check1(prog_busy, 1'b1);
    rd_status(st);
    check(st, spm_pkg::ST_ALL_ONES);
    wait_idle();
    check1(guard_pin_enable, 1'b1);
    check({6'h00, lock_sel}, 8'h03);
    rd_status(st);
    check(st, 8'h8c);
    check_locks(spm_pkg::LOCK_ALL);
    // guard low with enable set
    spm_host_model_i.set_guard(1'b0);
    prog(8'h04, 1'b1);
    check1(prog_busy, 1'b0);
    spm_host_model_i.set_guard(1'b1);
    // guard pulse while selected
    cmd(spm_pkg::OP_SET_LATCH);
    spm_host_model_i.select();
    spm_host_model_i.send_byte(spm_pkg::OP_STATUS_PROG, -1, -1, rx);
    spm_host_model_i.send_byte(8'h04, -1, -1, rx);
    spm_host_model_i.set_guard(1'b0);
    spm_host_model_i.set_guard(1'b1);
    spm_host_model_i.deselect();
    check1(prog_busy, 1'b0);
    check({6'h00, lock_sel}, 8'h03);
    // guard fall after the cycle started
    prog(8'h04, 1'b1);
    spm_host_model_i.set_guard(1'b0);
    wait_idle();
    check({6'h00, lock_sel}, 8'h01);
    check1(guard_pin_enable, 1'b0);
    check_locks(spm_pkg::LOCK_QTR);
    // guard low ignored with enable clear
    prog(8'h08, 1'b1);
    wait_idle();
    check({6'h00, lock_sel}, 8'h02);
    check_locks(spm_pkg::LOCK_HALF);
    spm_host_model_i.set_guard(1'b1);
    prog(8'h00, 1'b1);
    wait_idle();
    check_locks(spm_pkg::LOCK_NONE);
    // array cycle: busy status, latch cleared on completion
    cmd(spm_pkg::OP_SET_LATCH);
    arr_go <= 1'b1;
    @(posedge clk);
    arr_go <= 1'b0;
    rd_status(st);
    check(st, spm_pkg::ST_ALL_ONES);
    repeat (300) @(posedge clk);
    check1(prog_enable, 1'b0);
    rd_status(st);
    check(st, 8'h00);
    // reset in mid frame: no opcode until a fresh select fall
    cmd(spm_pkg::OP_SET_LATCH);
    spm_host_model_i.select();
    do_reset();
    check1(prog_enable, 1'b0);
    spm_host_model_i.send_byte(spm_pkg::OP_SET_LATCH, -1, -1, rx);
    spm_host_model_i.deselect();
    check1(prog_enable, 1'b0);
    cmd(spm_pkg::OP_SET_LATCH);
    check1(prog_enable, 1'b1);
    give_verdict();
  end
endmodule
